/* hdl/csb_pkg.sv */
// shared constants, types and decode helpers for the compare, skip and branch unit
package csb_pkg;

    // program counter counts 16-bit words; relative offset is a signed 7-bit field
    localparam int PC_W = 12;
    localparam int K_W = 7;

    // positions inside the status flags register
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // register port offsets
    localparam logic [1:0] OFS_STATUS = 2'h0;
    localparam logic [1:0] OFS_NEXT_PC = 2'h1;
    localparam logic [1:0] OFS_RESULT = 2'h2;

    // reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;

    // cycle counts and program counter steps
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [PC_W-1:0] STEP_NEXT = 12'h001;
    localparam logic [PC_W-1:0] STEP_SKIP_ONE_WORD = 12'h002;
    localparam logic [PC_W-1:0] STEP_SKIP_TWO_WORD = 12'h003;

    typedef enum logic [4:0] {
        compare_registers,
        compare_registers_with_borrow,
        compare_immediate,
        skip_reg_bit_clear,
        skip_reg_bit_set,
        skip_io_bit_clear,
        skip_io_bit_set,
        branch_flag_index_set,
        branch_flag_index_clear,
        branch_equal,
        branch_not_equal,
        branch_carry_set,
        branch_carry_clear,
        branch_unsigned_higher_same,
        branch_unsigned_lower,
        branch_negative,
        branch_positive,
        branch_signed_ge,
        branch_signed_less,
        branch_half_carry_set,
        branch_half_carry_clear,
        branch_transfer_bit_set,
        branch_transfer_bit_clear,
        branch_overflow_set,
        branch_overflow_clear
    } op_e;

    typedef enum logic [1:0] {
        st_idle = 2'h1,
        st_exec = 2'h2
    } state_e;

    // {is_branch, taken}; the signed pair looks at n xor v directly so it never
    // depends on whether the sign flag was kept up to date
    function automatic logic [1:0] branch_eval(op_e op, logic [2:0] idx, logic [7:0] f);
        logic [1:0] r;
        r = 2'h0;
        case (op)
            branch_flag_index_set: r = {1'b1, f[idx]};
            branch_flag_index_clear: r = {1'b1, ~f[idx]};
            branch_equal: r = {1'b1, f[FLAG_Z]};
            branch_not_equal: r = {1'b1, ~f[FLAG_Z]};
            branch_carry_set: r = {1'b1, f[FLAG_C]};
            branch_carry_clear: r = {1'b1, ~f[FLAG_C]};
            branch_unsigned_higher_same: r = {1'b1, ~f[FLAG_C]};
            branch_unsigned_lower: r = {1'b1, f[FLAG_C]};
            branch_negative: r = {1'b1, f[FLAG_N]};
            branch_positive: r = {1'b1, ~f[FLAG_N]};
            branch_signed_ge: r = {1'b1, ~(f[FLAG_N] ^ f[FLAG_V])}; // see [RQ11]
            branch_signed_less: r = {1'b1, f[FLAG_N] ^ f[FLAG_V]}; // see [RQ12]
            branch_half_carry_set: r = {1'b1, f[FLAG_H]}; // see [RQ13]
            branch_half_carry_clear: r = {1'b1, ~f[FLAG_H]};
            branch_transfer_bit_set: r = {1'b1, f[FLAG_T]}; // see [RQ14]
            branch_transfer_bit_clear: r = {1'b1, ~f[FLAG_T]};
            branch_overflow_set: r = {1'b1, f[FLAG_V]}; // see [RQ15]
            branch_overflow_clear: r = {1'b1, ~f[FLAG_V]};
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    // sign-extend the relative offset to program counter width
    function automatic logic [PC_W-1:0] sext_k(logic [K_W-1:0] k);
        return {{(PC_W-K_W){k[K_W-1]}}, k};
    endfunction

endpackage

/* hdl/cmp_if.sv */
// operand and flag bundle between the control unit and the compare subtractor
`timescale 1ns/1ps
interface cmp_if;
    logic [7:0] dest;
    logic [7:0] src;
    logic carry_in;
    logic flag_c;
    logic flag_z;
    logic flag_n;
    logic flag_v;
    logic flag_h;

    modport ctrl (output dest, output src, output carry_in,
                  input flag_c, input flag_z, input flag_n, input flag_v, input flag_h);
    modport alu (input dest, input src, input carry_in,
                 output flag_c, output flag_z, output flag_n, output flag_v, output flag_h);
endinterface

/* hdl/compare_alu.sv */
// subtractor that produces compare flags and throws the difference away
`timescale 1ns/1ps
module compare_alu (
    cmp_if.alu cmp
);
    logic [8:0] wide;
    logic [7:0] res;

    // nine bits so the borrow falls out as the top bit
    assign wide = {1'b0, cmp.dest} - {1'b0, cmp.src} - {8'h00, cmp.carry_in};
    assign res = wide[7:0];

    // borrow out of bit 7 and bit 3, two's-complement overflow of the difference
    assign cmp.flag_c = wide[8]; // see [RQ1]
    assign cmp.flag_z = (res == 8'h00);
    assign cmp.flag_n = res[7];
    assign cmp.flag_v = (cmp.dest[7] & ~cmp.src[7] & ~res[7]) |
                        (~cmp.dest[7] & cmp.src[7] & res[7]);
    assign cmp.flag_h = (~cmp.dest[3] & cmp.src[3]) | (cmp.src[3] & res[3]) |
                        (res[3] & ~cmp.dest[3]);
endmodule

/* hdl/compare_skip_branch_unit.sv */
// compare, conditional skip and relative branch execution with status flags
`timescale 1ns/1ps
// Function
// [RQ1] compares subtract register, register plus carry, or immediate, drop the result, set Z N V C H, one cycle.
// [RQ2] skip_reg_bit_clear adds 2 or 3 to the pc when the chosen register bit is zero, flags kept.
// [RQ3] skip_reg_bit_set adds 2 or 3 to the pc when the chosen register bit is one, flags kept.
// [RQ4] skip_io_bit_clear adds 2 or 3 to the pc when the chosen io register bit is zero, flags kept.
// [RQ5] skip_io_bit_set adds 2 or 3 to the pc when the chosen io register bit is one, flags kept.
// [RQ6] indexed branches test the status bit picked by a 3-bit index, set or clear, target pc plus k plus 1.
// [RQ7] equal branches on Z one and not-equal on Z zero, flags kept.
// [RQ8] carry branches test C set or clear, one or two cycles, flags kept.
// [RQ9] higher-or-same and lower behave exactly as carry clear and carry set.
// [RQ10] minus branches on N one and plus on N zero, target pc plus k plus 1.
// [RQ11] signed greater-or-equal branches when N xor V is zero.
// [RQ12] signed less-than branches when N xor V is one, flags kept.
// [RQ13] half-carry branches test H set or clear.
// [RQ14] transfer-bit branches test T set or clear, flags kept.
// [RQ15] overflow branches test V set or clear, target pc plus k plus 1.
// [RQ16] branches take one cycle untaken and two taken; skips take one, two or three cycles.
module compare_skip_branch_unit (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic issue_valid,
    output logic issue_ready,
    input wire csb_pkg::op_e op,
    input wire logic [7:0] rd_value,
    input wire logic [7:0] rr_value,
    input wire logic [7:0] imm_value,
    input wire logic [7:0] io_value,
    input wire logic [2:0] bit_sel,
    input wire logic [2:0] flag_sel,
    input wire logic [csb_pkg::K_W-1:0] offset_k,
    input wire logic [csb_pkg::PC_W-1:0] pc,
    input wire logic next_two_word,
    output logic done,
    output logic [csb_pkg::PC_W-1:0] next_pc,
    output logic [1:0] cycle_count,
    output logic flow_taken,
    output logic [7:0] status_flags,
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata
);
    typedef struct packed {
        csb_pkg::state_e state;
        logic [1:0] cnt;
        logic [7:0] status;
        logic [csb_pkg::PC_W-1:0] next_pc;
        logic [1:0] cycles;
        logic taken;
        logic done;
        logic [15:0] rdata;
    } core_s;

    core_s st_r;
    core_s st_nxt;
    logic accept;
    logic is_cmp;
    logic is_skip;
    logic [1:0] br;

    cmp_if cmp_bus ();

    compare_alu u_alu (
        .cmp(cmp_bus)
    );

    // operand steering for the subtractor; immediate form swaps the source
    assign cmp_bus.dest = rd_value;
    assign cmp_bus.src = (op == csb_pkg::compare_immediate) ? imm_value : rr_value;
    assign cmp_bus.carry_in = (op == csb_pkg::compare_registers_with_borrow) &
                              st_r.status[csb_pkg::FLAG_C];

    // classify the request
    assign is_cmp = (op == csb_pkg::compare_registers) ||
                    (op == csb_pkg::compare_registers_with_borrow) ||
                    (op == csb_pkg::compare_immediate);
    assign is_skip = (op == csb_pkg::skip_reg_bit_clear) || (op == csb_pkg::skip_reg_bit_set) ||
                     (op == csb_pkg::skip_io_bit_clear) || (op == csb_pkg::skip_io_bit_set);
    assign br = csb_pkg::branch_eval(op, flag_sel, st_r.status);
    assign issue_ready = (st_r.state == csb_pkg::st_idle);
    assign accept = issue_valid & issue_ready;

    // next-state logic; the core cannot issue again until the stall counter runs out
    always_comb begin
        logic test_bit;
        logic want;
        logic skip;
        st_nxt = st_r;
        test_bit = 1'b0;
        want = 1'b0;
        skip = 1'b0;
        st_nxt.done = 1'b0;
        st_nxt.rdata = 16'h0000;

        // register port: read data only in the cycle after the strobe
        if (reg_read) begin
            case (reg_addr)
                csb_pkg::OFS_STATUS: st_nxt.rdata = {8'h00, st_r.status};
                csb_pkg::OFS_NEXT_PC: st_nxt.rdata = {{(16-csb_pkg::PC_W){1'b0}}, st_r.next_pc};
                csb_pkg::OFS_RESULT: st_nxt.rdata = {13'h0000, st_r.taken, st_r.cycles};
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
        if (reg_write && (reg_addr == csb_pkg::OFS_STATUS)) begin
            st_nxt.status = reg_wdata[7:0];
        end

        case (st_r.state)
            csb_pkg::st_idle: begin
                if (accept) begin
                    st_nxt.taken = 1'b0;
                    st_nxt.cycles = csb_pkg::CYC_ONE;
                    st_nxt.next_pc = pc + csb_pkg::STEP_NEXT;
                    if (is_cmp) begin
                        // hardware flag update wins over a software write in the same cycle
                        st_nxt.status[csb_pkg::FLAG_C] = cmp_bus.flag_c; // see [RQ1]
                        st_nxt.status[csb_pkg::FLAG_Z] = cmp_bus.flag_z;
                        st_nxt.status[csb_pkg::FLAG_N] = cmp_bus.flag_n;
                        st_nxt.status[csb_pkg::FLAG_V] = cmp_bus.flag_v;
                        st_nxt.status[csb_pkg::FLAG_H] = cmp_bus.flag_h;
                    end else if (is_skip) begin
                        // register forms look at rr, io forms at the addressed io byte
                        if ((op == csb_pkg::skip_reg_bit_clear) ||
                            (op == csb_pkg::skip_reg_bit_set)) begin
                            test_bit = rr_value[bit_sel]; // see [RQ2] see [RQ3]
                        end else begin
                            test_bit = io_value[bit_sel]; // see [RQ4] see [RQ5]
                        end
                        want = (op == csb_pkg::skip_reg_bit_set) ||
                               (op == csb_pkg::skip_io_bit_set);
                        skip = (test_bit == want);
                        if (skip) begin
                            st_nxt.taken = 1'b1;
                            // skipped word count decides both step and cycle cost
                            if (next_two_word) begin
                                st_nxt.next_pc = pc + csb_pkg::STEP_SKIP_TWO_WORD; // see [RQ16]
                                st_nxt.cycles = csb_pkg::CYC_THREE;
                            end else begin
                                st_nxt.next_pc = pc + csb_pkg::STEP_SKIP_ONE_WORD;
                                st_nxt.cycles = csb_pkg::CYC_TWO;
                            end
                        end
                    end else if (br[1] && br[0]) begin
                        // taken branch: relative target, one extra cycle to refill fetch
                        st_nxt.taken = 1'b1; // see [RQ6] see [RQ7] see [RQ8] see [RQ9]
                        st_nxt.next_pc = pc + csb_pkg::sext_k(offset_k) + csb_pkg::STEP_NEXT;
                        st_nxt.cycles = csb_pkg::CYC_TWO; // see [RQ10] see [RQ16]
                    end
                    // single-cycle work finishes at once, longer work parks in exec
                    if (st_nxt.cycles == csb_pkg::CYC_ONE) begin
                        st_nxt.done = 1'b1;
                    end else begin
                        st_nxt.state = csb_pkg::st_exec;
                        st_nxt.cnt = st_nxt.cycles - csb_pkg::CYC_ONE;
                    end
                end
            end
            csb_pkg::st_exec: begin
                if (st_r.cnt == csb_pkg::CYC_ONE) begin
                    st_nxt.done = 1'b1;
                    st_nxt.state = csb_pkg::st_idle;
                end
                st_nxt.cnt = st_r.cnt - csb_pkg::CYC_ONE;
            end
            default: begin
                st_nxt.state = csb_pkg::st_idle;
                st_nxt.cnt = 2'h0;
            end
        endcase
    end

    // single state register for the whole unit
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r.state <= csb_pkg::st_idle;
            st_r.cnt <= 2'h0;
            st_r.status <= csb_pkg::STATUS_RESET;
            st_r.next_pc <= csb_pkg::PC_RESET;
            st_r.cycles <= 2'h0;
            st_r.taken <= 1'b0;
            st_r.done <= 1'b0;
            st_r.rdata <= 16'h0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign done = st_r.done;
    assign next_pc = st_r.next_pc;
    assign cycle_count = st_r.cycles;
    assign flow_taken = st_r.taken;
    assign status_flags = st_r.status;
    assign reg_rdata = st_r.rdata;

    // checks against independently computed expectations
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    AST_CMP_FLAGS: assert property (accept && op == csb_pkg::compare_registers |=> // see [RQ1]
        status_flags[csb_pkg::FLAG_Z] == ($past(rd_value) == $past(rr_value)) &&
        status_flags[csb_pkg::FLAG_C] == ($past(rd_value) < $past(rr_value)))
        else $error("compare flags wrong");
    AST_CMP_TIME: assert property (accept && is_cmp |=> // see [RQ1]
        done && cycle_count == 2'h1 && issue_ready)
        else $error("compare not single cycle");
    AST_SKIP_REG_CLR: assert property (accept && op == csb_pkg::skip_reg_bit_clear && // see [RQ2]
        !rr_value[bit_sel] && !next_two_word |=>
        next_pc == $past(pc) + 12'h002 && cycle_count == 2'h2)
        else $error("register clear skip wrong");
    AST_SKIP_REG_SET: assert property (accept && op == csb_pkg::skip_reg_bit_set && // see [RQ3]
        rr_value[bit_sel] && next_two_word |=>
        next_pc == $past(pc) + 12'h003 && cycle_count == 2'h3)
        else $error("register set skip wrong");
    AST_SKIP_IO_NONE: assert property (accept && op == csb_pkg::skip_io_bit_clear && // see [RQ4]
        io_value[bit_sel] |=> next_pc == $past(pc) + 12'h001 && !flow_taken && done)
        else $error("io clear skip taken wrongly");
    AST_SKIP_FLAGS: assert property (accept && is_skip && !reg_write |=> // see [RQ5]
        $stable(status_flags))
        else $error("skip altered flags");
    AST_BR_INDEX: assert property (accept && op == csb_pkg::branch_flag_index_set |=> // see [RQ6]
        flow_taken == $past(status_flags[flag_sel]))
        else $error("indexed branch decision wrong");
    AST_BR_EQ: assert property (accept && op == csb_pkg::branch_equal && // see [RQ7]
        status_flags[csb_pkg::FLAG_Z] |=>
        next_pc == $past(pc) + csb_pkg::sext_k($past(offset_k)) + 12'h001)
        else $error("equal branch target wrong");
    AST_BR_ALIAS: assert property (accept && op == csb_pkg::branch_unsigned_lower |=> // see [RQ9]
        flow_taken == $past(status_flags[csb_pkg::FLAG_C]))
        else $error("lower differs from carry set");
    AST_BR_GE: assert property (accept && op == csb_pkg::branch_signed_ge && // see [RQ11]
        (status_flags[csb_pkg::FLAG_N] ^ status_flags[csb_pkg::FLAG_V]) |=>
        next_pc == $past(pc) + 12'h001 && cycle_count == 2'h1)
        else $error("signed ge taken wrongly");
    AST_BR_FLAGS: assert property (accept && br[1] && !reg_write |=> // see [RQ12]
        $stable(status_flags))
        else $error("branch altered flags");
    AST_TWO_CYCLE: assert property (accept && br[1] && br[0] |=> // see [RQ16]
        !done && !issue_ready ##1 done)
        else $error("taken branch not two cycles");
    AST_THREE_CYCLE: assert property (accept && is_skip && next_two_word && // see [RQ16]
        cmp_bus.carry_in == 1'b0 && st_nxt.taken |=> !done [*2] ##1 done)
        else $error("long skip not three cycles");

    COV_COMPARE: cover property (accept && is_cmp ##1 done);
    COV_LONG_SKIP: cover property (accept && is_skip ##1 cycle_count == 2'h3 ##2 done);
    COV_TAKEN_BRANCH: cover property (accept && br[1] && br[0] ##2 done);
    COV_BACK_TO_BACK: cover property (done && accept ##1 done);
endmodule

/* verification/compare_skip_branch_unit_tb.sv */
// self-checking bench for the compare, skip and branch unit
`timescale 1ns/1ps
module compare_skip_branch_unit_tb;
    logic sys_clk;
    logic resetn;
    logic issue_valid;
    logic issue_ready;
    csb_pkg::op_e op;
    logic [7:0] rd_value, rr_value, imm_value, io_value, status_flags, exp_st;
    logic [2:0] bit_sel, flag_sel;
    logic [csb_pkg::K_W-1:0] offset_k;
    logic [csb_pkg::PC_W-1:0] pc, next_pc;
    logic next_two_word, done, flow_taken, reg_write, reg_read;
    logic [1:0] cycle_count, reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    int mismatches, tests_run, cycles;

    compare_skip_branch_unit dut (
        .sys_clk(sys_clk), .resetn(resetn), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .op(op), .rd_value(rd_value), .rr_value(rr_value),
        .imm_value(imm_value), .io_value(io_value), .bit_sel(bit_sel), .flag_sel(flag_sel),
        .offset_k(offset_k), .pc(pc), .next_two_word(next_two_word), .done(done),
        .next_pc(next_pc), .cycle_count(cycle_count), .flow_taken(flow_taken),
        .status_flags(status_flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata)
    );

    // free-running core clock, 8 ns period
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // hang guard: whole run needs well under 4000 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask

    // read data must stand in the one cycle after the strobe and be zero after that
    task automatic reg_rd(input logic [1:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, e, "read data");
        @(posedge sys_clk);
        #1;
        chk(reg_rdata, 16'h0000, "read data after its cycle");
    endtask

    // one issue; checks results at the accepting edge, busy while waiting, done latency
    task automatic run_op(input csb_pkg::op_e o, input logic [11:0] p, input logic [6:0] k,
            input logic two, input logic [11:0] epc, input logic [1:0] ecyc, input logic etk);
        int n;
        @(posedge sys_clk);
        issue_valid <= 1'b1;
        op <= o;
        pc <= p;
        offset_k <= k;
        next_two_word <= two;
        @(posedge sys_clk);
        issue_valid <= 1'b0;
        #1;
        chk(16'(next_pc), 16'(epc), "next pc");
        chk(16'(cycle_count), 16'(ecyc), "cycle count");
        chk(16'(flow_taken), 16'(etk), "taken");
        chk(16'(status_flags), 16'(exp_st), "status flags");
        n = 1;
        while (done !== 1'b1 && n < 5) begin
            chk(16'(issue_ready), 16'h0000, "ready while busy");
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(16'(n), 16'(ecyc), "done latency");
    endtask

    function automatic logic tgt_cond(input csb_pkg::op_e o, input logic [2:0] s,
            input logic [7:0] f);
        case (o)
            csb_pkg::branch_flag_index_set: return f[s];
            csb_pkg::branch_flag_index_clear: return ~f[s];
            csb_pkg::branch_equal: return f[1];
            csb_pkg::branch_not_equal: return ~f[1];
            csb_pkg::branch_carry_set, csb_pkg::branch_unsigned_lower: return f[0];
            csb_pkg::branch_carry_clear, csb_pkg::branch_unsigned_higher_same: return ~f[0];
            csb_pkg::branch_negative: return f[2];
            csb_pkg::branch_positive: return ~f[2];
            csb_pkg::branch_signed_ge: return ~(f[2] ^ f[3]);
            csb_pkg::branch_signed_less: return f[2] ^ f[3];
            csb_pkg::branch_half_carry_set: return f[5];
            csb_pkg::branch_half_carry_clear: return ~f[5];
            csb_pkg::branch_transfer_bit_set: return f[6];
            csb_pkg::branch_transfer_bit_clear: return ~f[6];
            csb_pkg::branch_overflow_set: return f[3];
            default: return ~f[3];
        endcase
    endfunction

    // every branch against patterns that set C, Z, N, V, H or T alone, all and none; pc wraps both ways
    task automatic branch_sweep();
        logic [7:0] pat [8] = '{8'h00, 8'hff, 8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40};
        logic t;
        logic [11:0] p;
        logic [6:0] k;
        for (int o = csb_pkg::branch_flag_index_set; o <= csb_pkg::branch_overflow_clear; o++) begin
            for (int i = 0; i < 8; i++) begin
                reg_wr(2'h0, {8'h00, pat[i]});
                exp_st = pat[i];
                flag_sel <= 3'(i);
                p = 12'((o - 12) * 20 + i * 2);
                k = 7'(i * 37 + o);
                t = tgt_cond(csb_pkg::op_e'(o), 3'(i), pat[i]);
                run_op(csb_pkg::op_e'(o), p, k, 1'b0,
                    t ? p + {{5{k[6]}}, k} + 12'h001 : p + 12'h001,
                    t ? 2'h2 : 2'h1, t);
            end
        end
    endtask

    // register and io bit skips over every bit, one- and two-word followers
    task automatic skip_sweep();
        logic t;
        logic [7:0] v;
        logic [1:0] c;
        reg_wr(2'h0, 16'h00c9);
        exp_st = 8'hc9;
        rr_value <= 8'ha5;
        io_value <= 8'h3c;
        for (int o = csb_pkg::skip_reg_bit_clear; o <= csb_pkg::skip_io_bit_set; o++) begin
            for (int i = 0; i < 16; i++) begin
                bit_sel <= 3'(i);
                v = (o < csb_pkg::skip_io_bit_clear) ? 8'ha5 : 8'h3c;
                t = (o == csb_pkg::skip_reg_bit_set || o == csb_pkg::skip_io_bit_set) ?
                    v[i % 8] : ~v[i % 8];
                c = t ? (i[3] ? 2'h3 : 2'h2) : 2'h1;
                run_op(csb_pkg::op_e'(o), 12'hffe, 7'h00, i[3],
                    12'hffe + 12'(c), c, t);
            end
        end
    endtask

    // the three compares, borrow in both states; sources differ so a wrong pick shows
    task automatic compare_sweep();
        logic [7:0] va [6] = '{8'h00, 8'h00, 8'h80, 8'h7f, 8'h10, 8'h05};
        logic [7:0] vb [6] = '{8'h00, 8'h01, 8'h01, 8'hff, 8'h01, 8'h05};
        logic [8:0] r;
        logic [7:0] a, b, s0;
        for (int o = 0; o < 3; o++) begin
            for (int i = 0; i < 12; i++) begin
                s0 = i[0] ? 8'hf1 : 8'h70;
                a = va[i / 2];
                b = vb[i / 2];
                reg_wr(2'h0, {8'h00, s0});
                rd_value <= a;
                rr_value <= (o == 2) ? ~b : b;
                imm_value <= (o == 2) ? b : ~b;
                r = {1'b0, a} - {1'b0, b} - ((o == 1) ? {8'h00, s0[0]} : 9'h000);
                exp_st = s0;
                exp_st[csb_pkg::FLAG_C] = r[8];
                exp_st[csb_pkg::FLAG_Z] = (r[7:0] == 8'h00);
                exp_st[csb_pkg::FLAG_N] = r[7];
                exp_st[csb_pkg::FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
                exp_st[csb_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
                run_op(csb_pkg::op_e'(o), 12'h123, 7'h3f, 1'b0, 12'h124, 2'h1, 1'b0);
            end
        end
    endtask

    // a compare held up while a two-word skip is busy must be ignored, not queued
    task automatic refuse_busy();
        reg_wr(2'h0, 16'h0000);
        rr_value <= 8'h01;
        bit_sel <= 3'h0;
        @(posedge sys_clk);
        issue_valid <= 1'b1;
        op <= csb_pkg::skip_reg_bit_set;
        pc <= 12'h200;
        next_two_word <= 1'b1;
        @(posedge sys_clk);
        op <= csb_pkg::compare_immediate;
        rd_value <= 8'h00;
        imm_value <= 8'h01;
        @(posedge sys_clk);
        @(posedge sys_clk);
        #1;
        chk(16'(done), 16'h0001, "done after skip");
        chk(16'(next_pc), 16'h0203, "skip target kept");
        chk(16'(status_flags), 16'h0000, "flags after ignored compare");
        // still valid in the done cycle: the waiting compare is taken back to back
        @(posedge sys_clk);
        issue_valid <= 1'b0;
        #1;
        chk(16'(done), 16'h0001, "back to back done");
        chk(16'(next_pc), 16'h0201, "back to back pc");
        chk(16'(status_flags), 16'h0025, "back to back flags");
        @(posedge sys_clk);
        #1;
        chk(16'(done), 16'h0000, "done one cycle");
    endtask

    // register port: status rw, read-only pc and result, unmapped offset
    task automatic reg_sweep();
        reg_wr(2'h0, 16'hff40);
        reg_rd(2'h0, 16'h0040);
        exp_st = 8'h40;
        run_op(csb_pkg::branch_transfer_bit_set, 12'h010, 7'h7f, 1'b0,
            12'h010, 2'h2, 1'b1);
        reg_wr(2'h1, 16'h0abc);
        reg_wr(2'h2, 16'h0001);
        reg_wr(2'h3, 16'h00ff);
        reg_rd(2'h1, 16'h0010);
        reg_rd(2'h2, 16'h0006);
        reg_rd(2'h3, 16'h0000);
        reg_rd(2'h0, 16'h0040);
    endtask

    initial begin
        resetn = 1'b0;
        issue_valid = 1'b0;
        op = csb_pkg::compare_registers;
        {rd_value, rr_value, imm_value, io_value} = 32'h0000_0000;
        {bit_sel, flag_sel, offset_k, pc, next_two_word} = 26'h000_0000;
        {reg_write, reg_read, reg_addr, reg_wdata} = 20'h0_0000;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        chk(16'(status_flags), 16'h0000, "reset flags");
        chk(16'(next_pc), 16'h0000, "reset pc");
        chk({done, issue_ready, reg_rdata[13:0]}, 16'h4000, "reset handshake");
        compare_sweep();
        skip_sweep();
        branch_sweep();
        refuse_busy();
        reg_sweep();
        print_verdict();
    end
endmodule
